// File: smc_asserts.sv
`timescale 1ns/1ps
module smc_asserts (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic lightload_off_enable,
   input wire logic overvoltage_sink_enable,
   input wire logic outputOvervoltage,
   input wire logic highz_idle,
   input wire logic [2:0] source_state_code,
   input wire logic sourceActive,
   input wire logic converterRun,
   input wire logic idleMode,
   input wire logic chargeDisable,
   input wire logic ovSinkOn,
   input wire logic [1:0] switchFreqSelect
);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   code_range_a: assert property (source_state_code <= 3'h4)
      else $error("state code out of range");
   code_idle_a: assert property (!sourceActive |-> source_state_code == 3'h0)
      else $error("state code set outside source mode");
   run_state_a: assert property (converterRun == (source_state_code inside {3'h1, 3'h2}))
      else $error("converter run does not match state");
   ll_hold_a: assert property (sourceActive && source_state_code == 3'h4
      |=> source_state_code == 3'h4 || !sourceActive)
      else $error("light-load off left while active");
   ll_gate_a: assert property (sourceActive && source_state_code != 3'h4
      && !lightload_off_enable |=> source_state_code != 3'h4)
      else $error("light-load off while disabled");
   entry_restart_a: assert property ($rose(sourceActive) |-> source_state_code == 3'h0)
      else $error("entry not in restart");
   fault_wait_a: assert property ($rose(source_state_code == 3'h3)
      |-> (source_state_code == 3'h3)[*8])
      else $error("fault wait too short");
   ov_sink_a: assert property (ovSinkOn == $past(overvoltage_sink_enable && outputOvervoltage))
      else $error("overvoltage sink wrong");
   idle_charge_a: assert property (chargeDisable == (highz_idle || sourceActive)
      && idleMode == !sourceActive)
      else $error("idle or charge disable wrong");
   freq_fixed_a: assert property (switchFreqSelect == 2'h2)
      else $error("switching frequency not default");

   cover property (source_state_code == 3'h2);
   cover property (source_state_code == 3'h3);
   cover property (source_state_code == 3'h4);
endmodule // smc_asserts

bind smc_source_mode_ctrl smc_asserts chk (.*);

// File: smc_host_model.sv
`timescale 1ns/1ps
module smc_host_model (
   input wire logic mclk,
   output logic source_request_n
);
   // ----------------------------------------------------------------
   // Request pin, push-pull from the host
   // ----------------------------------------------------------------
   initial source_request_n = 1'b1;
   task automatic setReq(input logic on);
      @(posedge mclk);
      source_request_n <= !on;
   endtask
   // cycle the request
   // Eight cycles high outlasts the three-stage pin synchroniser
   task automatic cycleReq();
      setReq(1'b0);
      repeat (8) @(posedge mclk);
      setReq(1'b1);
   endtask
endmodule // smc_host_model

// File: smc_pkg.sv
package smc_pkg;
   // ----------------------------------------------------------------
   // State codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SMC_RESTART = 3'b000,
      SMC_SOFT_START = 3'b001,
      SMC_REGULATE = 3'b010,
      SMC_FAULT_WAIT = 3'b011,
      SMC_LIGHTLOAD_OFF = 3'b100
   } smc_state_t;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint SMC_CLK_HZ = 125000000;
   localparam longint SMC_FAULT_WAIT_MS = 3000;
   localparam longint SMC_OV_EXIT_MS = 100;
   localparam longint SMC_LL_DELAY1_S = 10;
   localparam longint SMC_LL_DELAY2_S = 20;
   localparam longint SMC_LL_DELAY3_S = 30;
   localparam longint SMC_FAULT_WAIT_CYC = SMC_FAULT_WAIT_MS * SMC_CLK_HZ / 1000;
   localparam longint SMC_OV_EXIT_CYC = SMC_OV_EXIT_MS * SMC_CLK_HZ / 1000;
   localparam longint SMC_LL_DELAY1_CYC = SMC_LL_DELAY1_S * SMC_CLK_HZ;
   localparam longint SMC_LL_DELAY2_CYC = SMC_LL_DELAY2_S * SMC_CLK_HZ;
   localparam longint SMC_LL_DELAY3_CYC = SMC_LL_DELAY3_S * SMC_CLK_HZ;

   // ----------------------------------------------------------------
   // Droop and switching
   // ----------------------------------------------------------------
   localparam int SMC_DROOP_STEP_MV = 100;
   localparam int SMC_NORM_LOAD_MA = 2400;
   localparam logic [1:0] SMC_FSW_125K = 2'h0;
   localparam logic [1:0] SMC_FSW_250K = 2'h1;
   localparam logic [1:0] SMC_FSW_500K = 2'h2;
   localparam logic [1:0] SMC_FSW_1M = 2'h3;
   localparam logic [1:0] SMC_FSW_DEFAULT = SMC_FSW_500K;
endpackage

// File: smc_slew_ramp.sv
`timescale 1ns/1ps
module smc_slew_ramp
   import smc_pkg::*;
#(
   parameter int WIDTH = 11,
   parameter int STEP_CYC0 = 2,
   parameter int STEP_CYC1 = 4,
   parameter int STEP_CYC2 = 8,
   parameter int STEP_CYC3 = 20
)(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic run,
   input wire logic [WIDTH-1:0] target,
   input wire logic [1:0] slewSelect,
   output logic [WIDTH-1:0] level,
   output logic falling
);
   logic [15:0] stepCount;
   logic [15:0] stepLimit;
   wire stepTick = (stepCount >= stepLimit);

   assign stepLimit = (slewSelect == 2'h0) ? 16'(STEP_CYC0) :
                      (slewSelect == 2'h1) ? 16'(STEP_CYC1) :
                      (slewSelect == 2'h2) ? 16'(STEP_CYC2) : 16'(STEP_CYC3);
   assign falling = run && (level > target);

   // ----------------------------------------------------------------
   // Ramp
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!nrst || !run)
      begin
         stepCount <= 16'h0000;
         level <= target;
      end
      else if (level == target)
         stepCount <= 16'h0000;
      else if (stepTick)
      begin
         stepCount <= 16'h0000;
         level <= (level < target) ? level + 1'b1 : level - 1'b1;
      end
      else
         stepCount <= stepCount + 16'h0001;
   end
endmodule // smc_slew_ramp

// File: smc_source_mode_ctrl.sv
`timescale 1ns/1ps
module smc_source_mode_ctrl
   import smc_pkg::*;
#(
   parameter logic [1:0] FSW_SELECT = SMC_FSW_DEFAULT,
   parameter int CODE_WIDTH = 11,
   parameter int TEMP_WIDTH = 8,
   parameter longint FAULT_WAIT_CYC = SMC_FAULT_WAIT_CYC,
   parameter longint OV_EXIT_CYC = SMC_OV_EXIT_CYC,
   parameter longint LL_DELAY1_CYC = SMC_LL_DELAY1_CYC,
   parameter longint LL_DELAY2_CYC = SMC_LL_DELAY2_CYC,
   parameter longint LL_DELAY3_CYC = SMC_LL_DELAY3_CYC,
   parameter int SOFT_START_CYC = 1000
)(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic source_request_n,
   input wire logic sourceEnable,
   input wire logic highz_idle,
   input wire logic [1:0] droop_comp_select,
   input wire logic [11:0] outputCurrentMa,
   input wire logic lightload_off_enable,
   input wire logic [1:0] lightload_off_delay,
   input wire logic buckMode,
   input wire logic batteryAboveInput,
   input wire logic outputBelow6v,
   input wire logic currentBelow5ma,
   input wire logic [CODE_WIDTH-1:0] source_voltage_code,
   input wire logic internalFeedback,
   input wire logic voltage_source_select,
   input wire logic [1:0] voltage_slew_select,
   input wire logic ramp_down_sink_enable,
   input wire logic overvoltage_sink_enable,
   input wire logic outputOvervoltage,
   input wire logic outputUnder3v,
   input wire logic outputInRegulation,
   input wire logic thermistor_monitor_disable,
   input wire logic [TEMP_WIDTH-1:0] thermistor_input,
   input wire logic [TEMP_WIDTH-1:0] hotLimit0,
   input wire logic [TEMP_WIDTH-1:0] hotLimit1,
   input wire logic [TEMP_WIDTH-1:0] hotLimit2,
   input wire logic [TEMP_WIDTH-1:0] hotLimit3,
   input wire logic [1:0] hot_limit_select,
   input wire logic [TEMP_WIDTH-1:0] coldLimit0,
   input wire logic [TEMP_WIDTH-1:0] coldLimit1,
   input wire logic cold_limit_select,
   output logic [2:0] source_state_code,
   output logic sourceActive,
   output logic converterRun,
   output logic idleMode,
   output logic chargeDisable,
   output logic [CODE_WIDTH-1:0] voltageLevel,
   output logic [9:0] droopMv,
   output logic rampSinkOn,
   output logic ovSinkOn,
   output logic [1:0] switchFreqSelect
);
   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   logic [2:0] reqSync;
   logic reqPin;
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         reqSync <= 3'h7;
      else
         reqSync <= {reqSync[1:0], source_request_n};
   end
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         reqPin <= 1'b0;
      else if (reqSync[1] == reqSync[2])
         reqPin <= ~reqSync[2];
   end

   // ----------------------------------------------------------------
   // Mode control
   // ----------------------------------------------------------------
   logic ovExit;
   logic [39:0] ovCount;
   smc_state_t state, next_state;
   logic [39:0] waitCount;
   logic [39:0] llCount;
   logic [39:0] llLimit;

   wire wantSource = sourceEnable && reqPin && !highz_idle && !ovExit;
   assign idleMode = !sourceActive;
   assign chargeDisable = highz_idle || sourceActive;

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         sourceActive <= 1'b0;
      else
         sourceActive <= wantSource;
   end

   // overvoltage exit; latched until the request or sourceEnable is withdrawn
   always_ff @(posedge mclk)
   begin
      if (!nrst || !(sourceEnable && reqPin))
      begin
         ovCount <= 40'h0;
         ovExit <= 1'b0;
      end
      else if (sourceActive && outputOvervoltage)
      begin
         if (ovCount >= 40'(OV_EXIT_CYC))
            ovExit <= 1'b1;
         else
            ovCount <= ovCount + 40'h1;
      end
      else
         ovCount <= 40'h0;
   end

   // ----------------------------------------------------------------
   // Temperature window
   // ----------------------------------------------------------------
   wire [TEMP_WIDTH-1:0] hotSel = (hot_limit_select == 2'h0) ? hotLimit0 :
                                  (hot_limit_select == 2'h1) ? hotLimit1 :
                                  (hot_limit_select == 2'h2) ? hotLimit2 : hotLimit3;
   wire [TEMP_WIDTH-1:0] coldSel = cold_limit_select ? coldLimit1 : coldLimit0;
   // window compare (NTC: higher reading is colder)
   wire tempBad = !thermistor_monitor_disable &&
                  ((thermistor_input < hotSel) || (thermistor_input > coldSel));

   // ----------------------------------------------------------------
   // Light-load qualification
   // ----------------------------------------------------------------
   assign llLimit = (lightload_off_delay == 2'h0) ? 40'(LL_DELAY1_CYC) :
                    (lightload_off_delay == 2'h1) ? 40'(LL_DELAY2_CYC) : 40'(LL_DELAY3_CYC);
   wire llAllowed = sourceActive && buckMode && batteryAboveInput && outputBelow6v;
   wire llArmed = llAllowed && lightload_off_enable && (state == SMC_REGULATE);
   wire llDeclare = llArmed && currentBelow5ma && (llCount >= llLimit);

   always_ff @(posedge mclk)
   begin
      if (!nrst || !llArmed || !currentBelow5ma)
         llCount <= 40'h0;
      else if (llCount < llLimit)
         llCount <= llCount + 40'h1;
   end

   // ----------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      unique case (state)
         SMC_RESTART:
            if (!tempBad)
               next_state = SMC_SOFT_START;
         SMC_SOFT_START:
            if (waitCount >= 40'(SOFT_START_CYC))
               next_state = SMC_REGULATE;
         SMC_REGULATE:
            if (llDeclare)
               next_state = SMC_LIGHTLOAD_OFF;
            else if (outputUnder3v)
               next_state = SMC_FAULT_WAIT;
         SMC_FAULT_WAIT:
            if (waitCount >= 40'(FAULT_WAIT_CYC))
               next_state = SMC_RESTART;
         SMC_LIGHTLOAD_OFF:
            next_state = SMC_LIGHTLOAD_OFF;
         default:
            next_state = SMC_RESTART;
      endcase
      if (tempBad && state != SMC_LIGHTLOAD_OFF && state != SMC_FAULT_WAIT)
         next_state = SMC_RESTART;
      if (state == SMC_SOFT_START && outputUnder3v && !tempBad &&
          waitCount >= 40'(SOFT_START_CYC))
         next_state = SMC_FAULT_WAIT;
   end

   always_ff @(posedge mclk)
   begin
      // exit clears state; host cycles request to restart
      if (!nrst || !sourceActive)
         state <= SMC_RESTART;
      else
         state <= next_state;
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst || !sourceActive || next_state != state)
         waitCount <= 40'h0;
      else
         waitCount <= waitCount + 40'h1;
   end

   // status code; zero outside source mode
   assign source_state_code = sourceActive ? state : SMC_RESTART;
   assign converterRun = sourceActive &&
                         (state == SMC_SOFT_START || state == SMC_REGULATE);

   // ----------------------------------------------------------------
   // Voltage setpoint
   // ----------------------------------------------------------------
   logic [CODE_WIDTH-1:0] heldCode;
   logic falling;
   wire followCode = internalFeedback && !voltage_source_select;
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         heldCode <= source_voltage_code;
      else if (followCode || !sourceActive)
         heldCode <= source_voltage_code;
   end

   smc_slew_ramp #(.WIDTH(CODE_WIDTH)) slewRamp (
      .mclk(mclk),
      .nrst(nrst),
      .run(converterRun),
      .target(heldCode),
      .slewSelect(voltage_slew_select),
      .level(voltageLevel),
      .falling(falling)
   );

   always_ff @(posedge mclk)
   begin
      if (!nrst || !ramp_down_sink_enable || !converterRun)
         rampSinkOn <= 1'b0;
      else if (falling)
         rampSinkOn <= 1'b1;
      else if (outputInRegulation)
         rampSinkOn <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
         ovSinkOn <= 1'b0;
      else
         ovSinkOn <= overvoltage_sink_enable && outputOvervoltage;
   end

   // ----------------------------------------------------------------
   // Droop compensation
   // ----------------------------------------------------------------
   // linear lift; no clipping, the 12-bit current input tops out at 4095mA
   wire [21:0] droopProd = 22'(droop_comp_select) * 22'(SMC_DROOP_STEP_MV) *
                           22'(outputCurrentMa);
   wire [21:0] droopQ = droopProd / 22'(SMC_NORM_LOAD_MA);
   always_ff @(posedge mclk)
   begin
      if (!nrst || !converterRun)
         droopMv <= 10'h000;
      else
         droopMv <= droopQ[9:0];
   end

   assign switchFreqSelect = FSW_SELECT;
endmodule // smc_source_mode_ctrl

// File: smc_source_mode_ctrl_tb.sv
`timescale 1ns/1ps
module smc_source_mode_ctrl_tb;
   logic mclk, nrst, source_request_n, sourceEnable, highz_idle, lightload_off_enable;
   logic [1:0] droop_comp_select, lightload_off_delay, voltage_slew_select, hot_limit_select;
   logic [11:0] outputCurrentMa;
   logic buckMode, batteryAboveInput, outputBelow6v, currentBelow5ma, internalFeedback;
   logic [10:0] source_voltage_code, voltageLevel;
   logic voltage_source_select, ramp_down_sink_enable, overvoltage_sink_enable;
   logic outputOvervoltage, outputUnder3v, outputInRegulation, thermistor_monitor_disable;
   logic [7:0] thermistor_input, hotLimit0, hotLimit1, hotLimit2, hotLimit3, coldLimit0, coldLimit1;
   logic cold_limit_select, sourceActive, converterRun, idleMode, chargeDisable, rampSinkOn;
   logic ovSinkOn;
   logic [2:0] source_state_code;
   logic [9:0] droopMv;
   logic [1:0] switchFreqSelect;
   int fail_count = 0;
   int n_checks = 0;
   int lim;

   // ----------------------------------------------------------------
   // Harness
   // ----------------------------------------------------------------
   // Short counts keep the run small; expectations use the same figures
   smc_host_model host (.mclk(mclk), .source_request_n(source_request_n));
   smc_source_mode_ctrl #(.FAULT_WAIT_CYC(20), .OV_EXIT_CYC(20), .LL_DELAY1_CYC(20),
      .LL_DELAY2_CYC(40), .LL_DELAY3_CYC(60), .SOFT_START_CYC(20)) dut (.*);

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic waitCode(input logic [2:0] want, input int bound);
      for (int i = 0; i < bound && source_state_code !== want; i++)
         @(negedge mclk);
      check(source_state_code, want);
      if (source_state_code !== want)
         close_out();
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      {nrst, highz_idle, droop_comp_select, lightload_off_enable, lightload_off_delay} = '0;
      {buckMode, batteryAboveInput, outputBelow6v, currentBelow5ma, voltage_slew_select} = '0;
      {voltage_source_select, ramp_down_sink_enable, overvoltage_sink_enable} = '0;
      {outputOvervoltage, outputUnder3v, thermistor_monitor_disable, hot_limit_select} = '0;
      cold_limit_select = 1'b0;
      {sourceEnable, internalFeedback, outputInRegulation} = 3'h7;
      outputCurrentMa = 12'h3e8;
      source_voltage_code = 11'h040;
      thermistor_input = 8'h64;
      {hotLimit3, hotLimit2, hotLimit1, hotLimit0} = 32'h281e140a;
      {coldLimit1, coldLimit0} = 16'hdcc8;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      repeat (200) @(negedge mclk);
      check({idleMode, source_state_code}, 4'h8);
      check(switchFreqSelect, 2'h2);
      host.setReq(1'b1);
      waitCode(3'h1, 20);
      waitCode(3'h2, 40);
      for (int s = 0; s < 4; s++)
      begin
         @(posedge mclk);
         droop_comp_select <= 2'(s);
         outputCurrentMa <= 12'h960;
         repeat (3) @(negedge mclk);
         check(droopMv, 16'(s * 100));
         @(posedge mclk);
         outputCurrentMa <= 12'h4b0;
         repeat (3) @(negedge mclk);
         check(droopMv, 16'(s * 50));
      end
      @(posedge mclk);
      voltage_slew_select <= 2'h3;
      source_voltage_code <= 11'h048;
      repeat (40) @(negedge mclk);
      check(voltageLevel == 11'h048, 1'b0);
      repeat (300) @(negedge mclk);
      check(voltageLevel, 11'h048);
      @(posedge mclk);
      voltage_slew_select <= 2'h0;
      ramp_down_sink_enable <= 1'b1;
      outputInRegulation <= 1'b0;
      source_voltage_code <= 11'h040;
      repeat (3) @(negedge mclk);
      check(rampSinkOn, 1'b1);
      repeat (30) @(negedge mclk);
      check(voltageLevel, 11'h040);
      @(posedge mclk);
      outputInRegulation <= 1'b1;
      voltage_source_select <= 1'b1;
      source_voltage_code <= 11'h050;
      repeat (60) @(negedge mclk);
      check({rampSinkOn, voltageLevel}, 12'h040);
      // External feedback must also freeze the level
      @(posedge mclk);
      voltage_source_select <= 1'b0;
      internalFeedback <= 1'b0;
      repeat (60) @(negedge mclk);
      check(voltageLevel, 11'h040);
      @(posedge mclk);
      internalFeedback <= 1'b1;
      voltage_source_select <= 1'b0;
      source_voltage_code <= 11'h040;
      overvoltage_sink_enable <= 1'b1;
      outputOvervoltage <= 1'b1;
      repeat (5) @(negedge mclk);
      check(ovSinkOn, 1'b1);
      @(posedge mclk);
      outputOvervoltage <= 1'b0;
      outputUnder3v <= 1'b1;
      waitCode(3'h3, 5);
      @(posedge mclk);
      outputUnder3v <= 1'b0;
      waitCode(3'h0, 40);
      waitCode(3'h2, 60);
      // Thermistor reads 35 against hot limit 40: too hot
      @(posedge mclk);
      thermistor_input <= 8'h23;
      hot_limit_select <= 2'h3;
      waitCode(3'h0, 5);
      repeat (30) @(negedge mclk);
      check(source_state_code, 3'h0);
      @(posedge mclk);
      thermistor_monitor_disable <= 1'b1;
      waitCode(3'h2, 60);
      @(posedge mclk);
      thermistor_monitor_disable <= 1'b0;
      hot_limit_select <= 2'h2;
      thermistor_input <= 8'hd2;
      waitCode(3'h0, 5);
      @(posedge mclk);
      cold_limit_select <= 1'b1;
      waitCode(3'h2, 60);
      // Cold limit below the reading is out of window again
      @(posedge mclk);
      coldLimit1 <= 8'hd0;
      waitCode(3'h0, 5);
      @(posedge mclk);
      coldLimit1 <= 8'hdc;
      waitCode(3'h2, 60);
      @(posedge mclk);
      currentBelow5ma <= 1'b1;
      for (int g = 0; g < 4; g++)
      begin
         @(posedge mclk);
         {lightload_off_enable, buckMode, batteryAboveInput, outputBelow6v} <= 4'hf ^ (4'h8 >> g);
         repeat (80) @(negedge mclk);
         check(source_state_code, 3'h2);
      end
      for (int d = 0; d < 4; d++)
      begin
         lim = (d == 0) ? 20 : (d == 1) ? 40 : 60;
         @(posedge mclk);
         lightload_off_delay <= 2'(d);
         {lightload_off_enable, buckMode, batteryAboveInput, outputBelow6v} <= 4'hf;
         repeat (lim / 2) @(posedge mclk);
         currentBelow5ma <= 1'b0;
         repeat (2) @(posedge mclk);
         currentBelow5ma <= 1'b1;
         repeat (lim - 3) @(negedge mclk);
         check(source_state_code, 3'h2);
         waitCode(3'h4, 8);
         repeat (20) @(negedge mclk);
         check({converterRun, source_state_code}, 4'h4);
         host.cycleReq();
         waitCode(3'h2, 100);
      end
      @(posedge mclk);
      currentBelow5ma <= 1'b0;
      outputOvervoltage <= 1'b1;
      repeat (30) @(negedge mclk);
      check({sourceActive, idleMode}, 2'h1);
      @(posedge mclk);
      outputOvervoltage <= 1'b0;
      host.cycleReq();
      waitCode(3'h2, 100);
      // Software enable withdrawn leaves source mode
      @(posedge mclk);
      sourceEnable <= 1'b0;
      repeat (3) @(negedge mclk);
      check({sourceActive, idleMode, source_state_code}, 5'h08);
      @(posedge mclk);
      sourceEnable <= 1'b1;
      waitCode(3'h2, 60);
      @(posedge mclk);
      highz_idle <= 1'b1;
      repeat (5) @(negedge mclk);
      check({sourceActive, chargeDisable, source_state_code}, 5'h08);
      close_out();
   end
endmodule // smc_source_mode_ctrl_tb
